// ==== frontend_model.sv ====
/* behavioural front end: event capture, sparse readout, kill mask.
   assumes the controller drives its pins; hits and veto come from bench calls. */
`timescale 1ns/1ps
module frontend_model (
  // controller side
  input  wire       enable_i,
  input  wire       request_i,
  input  wire       reset_i,
  input  wire       select_i,
  input  wire       mask_data_i,
  input  wire       mask_shift_clock_i,
  // readout pins
  output wire       pending_o,
  output wire [3:0] chan_addr_o
);
  reg [15:0] shift_q = 16'h0000;
  reg [15:0] kill_q  = 16'h0000;
  reg [15:0] held_q  = 16'h0000;
  reg        pend_q  = 1'b0;
  reg [3:0]  addr_q  = 4'h0;
  reg [4:0]  nread_q = 5'h00;
  integer    c;

  // ****************
  // pins
  // ****************
  // index held; a floated bus shows the inverse
  assign chan_addr_o = enable_i ? addr_q : ~addr_q;
  assign pending_o   = pend_q;

  task fire(input [15:0] hits, input veto);
    if (!veto && !pend_q && (hits & ~kill_q) != 16'h0000) begin
      pend_q  <= 1'b1;
      held_q  <= hits & ~kill_q;
      nread_q <= 5'h00;
    end
  endtask

  // lowest remaining channel on each request
  always @(posedge request_i) begin
    if (enable_i && held_q != 16'h0000) begin
      for (c = 15; c >= 0; c = c - 1)
        if (held_q[c]) addr_q = 4'(c);
      held_q[addr_q] = 1'b0;
      nread_q = nread_q + 5'h01;
    end
  end

  // pending drops at the fall of the last request
  always @(negedge request_i)
    if (enable_i && pend_q && held_q == 16'h0000) pend_q = 1'b0;

  always @(posedge reset_i) begin
    pend_q = 1'b0;
    held_q = 16'h0000;
  end

  // shift on falling clock while selected
  always @(negedge mask_shift_clock_i)
    if (select_i) shift_q = {shift_q[14:0], mask_data_i};

  always @(negedge select_i) kill_q = shift_q;
endmodule

// ==== readout_ctrl.v ====
/* external readout controller for a 16-channel sparse-readout detector front end.
 * assumes software on classic wishbone and the device pins wired directly;
 * all device inputs are asynchronous and are synchronised here. */
// Summary of operation
// - wait 1 us, then assert freeze
// - enable within 30 us of freeze
// - request 250 ns after enable, 500 ns
// - drop enable after last channel
// - hold freeze, then send reset pulse (here freeze drops with enable as the reset pulse starts)
// - assert select before loading mask
// - bit set at clock rise, 16 cycles
`timescale 1ns/1ps
`include "readout_ctrl_defs.vh"

module readout_ctrl (
  // clock and reset
  input  wire        clk_i,
  input  wire        nrst_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // device readout pins
  input  wire        pending_i,
  input  wire [3:0]  chan_addr_i,
  output reg         freeze_line_o,
  output reg         enable_o,
  output reg         request_o,
  output reg         dev_reset_o,
  // device mask loading pins
  output reg         select_o,
  output reg         mask_data_o,
  output reg         mask_shift_clock_o
);
  // ****************************************
  // states
  // ****************************************
  localparam [6:0] S_IDLE   = 7'b000_0001;
  localparam [6:0] S_WAIT   = 7'b000_0010;
  localparam [6:0] S_FREEZE = 7'b000_0100;
  localparam [6:0] S_ENAB   = 7'b000_1000;
  localparam [6:0] S_REQ    = 7'b001_0000;
  localparam [6:0] S_LOW    = 7'b010_0000;
  localparam [6:0] S_RST    = 7'b100_0000;
  localparam [2:0] M_IDLE   = 3'b001;
  localparam [2:0] M_SHIFT  = 3'b010;
  localparam [2:0] M_END    = 3'b100;

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg  [4:0]  sync1_q;
  reg  [4:0]  sync2_q;
  wire        pend_s = sync2_q[4];
  wire [3:0]  addr_s = sync2_q[3:0];
  // two flops before any logic sees device pins
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {pending_i, chan_addr_i};
      sync2_q <= sync1_q;
    end
  end

  // ****************************************
  // registers and state
  // ****************************************
  reg         arm_q, load_go_q, reset_go_q, done_q, item_q;
  reg  [15:0] enwait_q, mask_q, tmr_q, mtmr_q, mshift_q;
  reg  [3:0]  item_addr_q;
  reg  [4:0]  count_q, mbit_q;
  reg  [6:0]  st_q;
  reg  [2:0]  mst_q;
  // wishbone write strobe for a given offset
  function wr_hit;
    input [3:0] adr, off;
    wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & (adr == off);
  endfunction

  // ****************************************
  // wishbone slave, one wait state then ack
  // ****************************************
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0000_0000;
      arm_q      <= 1'b0;
      enwait_q   <= `CTRL_ENWAIT_RST;
      mask_q     <= 16'h0000;
      load_go_q  <= 1'b0;
      reset_go_q <= 1'b0;
    end else begin
      wb_ack_o   <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      load_go_q  <= 1'b0;
      reset_go_q <= 1'b0;
      wb_dat_o   <= 32'h0000_0000;
      if (wr_hit(wb_adr_i, `REG_CTRL)) begin
        if (wb_sel_i[0]) begin
          arm_q      <= wb_dat_i[`CTRL_ARM_BIT];
          load_go_q  <= wb_dat_i[`CTRL_LOAD_BIT];
          reset_go_q <= wb_dat_i[`CTRL_RESET_BIT];
        end
        if (wb_sel_i[2]) enwait_q[7:0] <= wb_dat_i[23:16];
        if (wb_sel_i[3]) enwait_q[15:8] <= wb_dat_i[31:24];
      end else if (wr_hit(wb_adr_i, `REG_MASK)) begin
        if (wb_sel_i[0]) mask_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) mask_q[15:8] <= wb_dat_i[15:8];
      end
      // read mux; unmapped offsets read zero and still ack
      if (wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_we_i) begin
        if (wb_adr_i == `REG_CTRL) wb_dat_o <= {enwait_q, 15'h0000, arm_q};
        else if (wb_adr_i == `REG_STATUS)
          wb_dat_o <= {19'h0_0000, count_q, 3'h0, (mst_q != M_IDLE), pend_s,
                       done_q, item_q, (st_q != S_IDLE)};
        else if (wb_adr_i == `REG_MASK) wb_dat_o <= {16'h0000, mask_q};
        else if (wb_adr_i == `REG_ITEM) wb_dat_o <= {28'h000_0000, item_addr_q};
      end
    end
  end

  // ****************************************
  // readout sequencer
  // ****************************************
  wire rd_item = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o & (wb_adr_i == `REG_ITEM);
  wire rd_stat = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o & (wb_adr_i == `REG_STATUS);
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q          <= S_IDLE;
      tmr_q         <= 16'h0000;
      freeze_line_o <= 1'b0;
      enable_o      <= 1'b0;
      request_o     <= 1'b0;
      dev_reset_o   <= 1'b0;
      item_q        <= 1'b0;
      item_addr_q   <= 4'h0;
      done_q        <= 1'b0;
      count_q       <= 5'h00;
    end else begin
      tmr_q <= tmr_q + 16'h0001;
      // new item wins over the read that clears it
      if (rd_item) item_q <= 1'b0;
      if (rd_stat) done_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          tmr_q <= 16'h0000;
          if (arm_q & pend_s)
            st_q <= S_WAIT;
          else if (reset_go_q) begin
            dev_reset_o <= 1'b1;
            st_q        <= S_RST;
          end
        end
        S_WAIT: begin
          if (tmr_q >= (`FREEZE_WAIT_CYC - 1)) begin
            freeze_line_o <= 1'b1;
            tmr_q         <= 16'h0000;
            count_q       <= 5'h00;
            st_q          <= S_FREEZE;
          end
        end
        S_FREEZE: begin
          // enable within the 30 us limit
          if ((tmr_q >= enwait_q) || (tmr_q >= (`ENABLE_MAX_CYC - 1))) begin
            enable_o <= 1'b1;
            tmr_q    <= 16'h0000;
            st_q     <= S_ENAB;
          end
        end
        S_ENAB: begin
          // first request 250 ns after enable
          if (tmr_q >= (`REQ_GAP_CYC - 1)) begin
            request_o <= 1'b1;
            tmr_q     <= 16'h0000;
            st_q      <= S_REQ;
          end
        end
        S_REQ: begin
          // request held 500 ns, data valid by its end
          if (tmr_q >= (`REQ_WIDTH_CYC - 1)) begin
            request_o   <= 1'b0;
            item_q      <= 1'b1;
            item_addr_q <= addr_s;
            count_q     <= count_q + 5'h01;
            tmr_q       <= 16'h0000;
            st_q        <= S_LOW;
          end
        end
        S_LOW: begin
          // pending drops at last request fall; wait for sync delay
          if (tmr_q >= (`REQ_WIDTH_CYC - 1)) begin
            tmr_q <= 16'h0000;
            if (pend_s && (count_q < 5'h10)) begin
              request_o <= 1'b1;
              st_q      <= S_REQ;
            end else begin
              // drop enable after last item or at the cap
              enable_o      <= 1'b0;
              freeze_line_o <= 1'b0;
              dev_reset_o   <= 1'b1;
              done_q        <= 1'b1;
              st_q          <= S_RST;
            end
          end
        end
        S_RST: begin
          if (tmr_q >= (`RST_WIDTH_CYC - 1)) begin
            dev_reset_o <= 1'b0;
            st_q        <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // kill mask loader
  // ****************************************
  // only starts while the readout sequencer is idle; a readout can still begin while select is high
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mst_q              <= M_IDLE;
      mtmr_q             <= 16'h0000;
      mbit_q             <= 5'h00;
      mshift_q           <= 16'h0000;
      select_o           <= 1'b0;
      mask_data_o        <= 1'b0;
      mask_shift_clock_o <= 1'b0;
    end else begin
      mtmr_q <= mtmr_q + 16'h0001;
      case (mst_q)
        M_IDLE: begin
          mtmr_q <= 16'h0000;
          if (load_go_q & (st_q == S_IDLE)) begin
            select_o <= 1'b1;
            mshift_q <= mask_q;
            mbit_q   <= 5'h00;
            mst_q    <= M_SHIFT;
          end
        end
        M_SHIFT: begin
          if (mtmr_q >= (`MASK_HALF_CYC - 1)) begin
            mtmr_q <= 16'h0000;
            if (!mask_shift_clock_o) begin
              if (mbit_q == `MASK_BITS) begin
                mst_q <= M_END;
              end else begin
                // bit changes with the rising clock edge, msb first
                mask_shift_clock_o <= 1'b1;
                mask_data_o        <= mshift_q[15];
                mshift_q           <= {mshift_q[14:0], 1'b0};
                mbit_q             <= mbit_q + 5'h01;
              end
            end else
              mask_shift_clock_o <= 1'b0;
          end
        end
        M_END: begin
          // select falls to latch the word
          select_o    <= 1'b0;
          mask_data_o <= 1'b0;
          mst_q       <= M_IDLE;
        end
        default: mst_q <= M_IDLE;
      endcase
    end
  end
endmodule

// ==== readout_ctrl_defs.vh ====
/*
 * timing constants and register map of the front-end readout controller.
 * assumes a 100 MHz system clock; included by the controller only.
 */
`ifndef READOUT_CTRL_DEFS_VH
`define READOUT_CTRL_DEFS_VH

// clock period in ns
`define CLK_PERIOD_NS      10
// wait from event pending to freeze, ns (least time, round up)
`define FREEZE_WAIT_NS     1000
`define FREEZE_WAIT_CYC    ((`FREEZE_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// longest wait from freeze to enable, ns (round down)
`define ENABLE_MAX_NS      30000
`define ENABLE_MAX_CYC     (`ENABLE_MAX_NS / `CLK_PERIOD_NS)
// enable to first request, ns
`define REQ_GAP_NS         250
`define REQ_GAP_CYC        ((`REQ_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// request pulse width and data valid time, ns
`define REQ_WIDTH_NS       500
`define REQ_WIDTH_CYC      ((`REQ_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// reset pulse width, ns
`define RST_WIDTH_NS       1000
`define RST_WIDTH_CYC      ((`RST_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// half period of the mask shift clock (100 kHz max), ns
`define MASK_HALF_NS       5000
`define MASK_HALF_CYC      ((`MASK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// number of mask bits
`define MASK_BITS          16

// register byte offsets
`define REG_CTRL           4'h0
`define REG_STATUS         4'h4
`define REG_MASK           4'h8
`define REG_ITEM           4'hc

// control register fields
`define CTRL_ARM_BIT       0
`define CTRL_LOAD_BIT      1
`define CTRL_RESET_BIT     2
`define CTRL_ENWAIT_LSB    16
`define CTRL_ENWAIT_W      16
`define CTRL_ENWAIT_RST    16'h0000

// status register fields
`define STAT_BUSY_BIT      0
`define STAT_ITEM_BIT      1
`define STAT_DONE_BIT      2
`define STAT_PEND_BIT      3
`define STAT_MBUSY_BIT     4
`define STAT_COUNT_LSB     8

`endif

// ==== readout_ctrl_sva.sv ====
/* port checker for the readout controller.
   assumes a bind from the bench top; one clock, async low reset. */
`timescale 1ns/1ps
module readout_ctrl_sva (
  // clock, reset and bus
  input wire        clk_i,
  input wire        nrst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  // device pins
  input wire        pending_i,
  input wire        freeze_line_o,
  input wire        enable_o,
  input wire        request_o,
  input wire        dev_reset_o,
  input wire        select_o,
  input wire        mask_data_o,
  input wire        mask_shift_clock_o
);
  reg [7:0] hi_cnt_q;

  // length of the current request pulse, too long for a repetition
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) hi_cnt_q <= 8'h00;
    else if (request_o) hi_cnt_q <= hi_cnt_q + 8'h01;
    else hi_cnt_q <= 8'h00;
  end

  // ****************
  // checks
  // ****************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  freeze_wait_a: assert property ($rose(freeze_line_o) |-> $past(pending_i, 100))
    else $error("freeze too early");
  first_req_a: assert property ($rose(enable_o) |-> ##25 $rose(request_o))
    else $error("first request mistimed");
  req_width_a: assert property ($fell(request_o) |-> hi_cnt_q == 8'h32)
    else $error("request width wrong");
  req_enabled_a: assert property (request_o |-> enable_o && freeze_line_o)
    else $error("request outside enable");
  reset_pulse_a: assert property ($rose(dev_reset_o) |-> ##99 dev_reset_o ##1 !dev_reset_o)
    else $error("reset pulse width wrong");
  clk_in_select_a: assert property (mask_shift_clock_o |-> select_o)
    else $error("mask clock without select");
  data_at_rise_a: assert property ($changed(mask_data_o) && $past(select_o) && select_o
    |-> $rose(mask_shift_clock_o))
    else $error("mask data moved off clock rise");
  enable_drop_a: assert property ($fell(enable_o) |-> $rose(dev_reset_o) && !freeze_line_o)
    else $error("enable dropped without reset pulse");
endmodule

// ==== readout_ctrl_tb_top.sv ====
/* bench top for the readout controller with the front-end model.
   assumes controller, header, model and checker are compiled first. */
`timescale 1ns/1ps
module readout_ctrl_tb_top;
  logic        clk_i = 0, nrst_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0000_0000, st;
  wire  [31:0] wb_dat_o;
  wire  [3:0]  chan_addr_i;
  wire         wb_ack_o, pending_i, freeze_line_o, enable_o, request_o, dev_reset_o;
  wire         select_o, mask_data_o, mask_shift_clock_o;
  integer      num_errors = 0, checked = 0, i;

  readout_ctrl dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pending_i(pending_i),
    .chan_addr_i(chan_addr_i), .freeze_line_o(freeze_line_o), .enable_o(enable_o),
    .request_o(request_o), .dev_reset_o(dev_reset_o), .select_o(select_o),
    .mask_data_o(mask_data_o), .mask_shift_clock_o(mask_shift_clock_o));
  frontend_model model_u (.enable_i(enable_o), .request_i(request_o),
    .reset_i(dev_reset_o), .select_i(select_o), .mask_data_i(mask_data_o),
    .mask_shift_clock_i(mask_shift_clock_o), .pending_o(pending_i), .chan_addr_o(chan_addr_i));

  always #5 clk_i = ~clk_i;

  // ****************
  // tasks
  // ****************
  task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("unexpected %0s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic cycle; request held until ack is sampled
  task wb(input we, input [3:0] a, input [31:0] d);
    integer n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin @(posedge clk_i); n = n + 1; end while (wb_ack_o !== 1'b1 && n < 50);
    if (n == 50) num_errors = num_errors + 1;
    st = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // status polling, spaced out so the bank can progress
  task poll(input integer b, input v);
    integer k;
    k = 0;
    do begin repeat (50) @(posedge clk_i); wb(0, 4'h4, 0); k = k + 1; end
    while (st[b] !== v && k < 500);
    if (st[b] !== v) num_errors = num_errors + 1;
  endtask
  // one bank with a late hit and a late veto mid-readout
  task bank(input [15:0] h, input [4:0] n, input [3:0] last);
    model_u.fire(h, 1'b0);
    repeat (150) @(posedge clk_i);
    model_u.fire(16'h0010, 1'b0);
    model_u.fire(16'h0010, 1'b1);
    poll(2, 1'b1);
    chk("count", st[12:8], n);
    wb(0, 4'hc, 0);
    chk("item", st, last);
    chk("reads", model_u.nread_q, n);
    chk("pending", pending_i, 0);
    repeat (200) @(posedge clk_i);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************
  // sequence
  // ****************
  initial begin
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (i = 0; i < 5; i = i + 1) begin
      wb(0, (i == 4) ? 4'h2 : 4'(i * 4), 0);
      chk("reset", st, 0);
    end
    chk("kill", model_u.kill_q, 0);
    wb(1, 4'h8, 32'h0000_a5c3);
    wb(1, 4'h0, 32'h0000_0002);
    poll(4, 1'b0);
    chk("kill", model_u.kill_q, 16'ha5c3);
    wb(1, 4'h0, 32'h0000_0001);
    bank(16'h1235, 5'h05, 4'hc);
    wb(1, 4'h0, 32'h0010_0001);
    wb(0, 4'h0, 0);
    chk("ctrl", st, 32'h0010_0001);
    bank(16'h0004, 5'h01, 4'h2);
    model_u.fire(16'h0001, 1'b0);
    repeat (300) @(posedge clk_i);
    chk("killed", pending_i, 0);
    model_u.fire(16'h0010, 1'b1);
    repeat (300) @(posedge clk_i);
    wb(0, 4'h4, 0);
    chk("busy", st[0], 0);
    chk("freeze", freeze_line_o, 0);
    chk("vetoed", pending_i, 0);
    // unarmed pending is ignored; a manual reset pulse clears it
    wb(1, 4'h0, 32'h0000_0000);
    model_u.fire(16'h0010, 1'b0);
    repeat (10) @(posedge clk_i);
    wb(0, 4'h4, 0);
    chk("unarmed", st[4:0], 5'h08);
    wb(1, 4'h0, 32'h0000_0004);
    repeat (150) @(posedge clk_i);
    chk("cleared", pending_i, 0);
    wrap_up;
  end

  // watchdog against a hung handshake
  initial begin
    repeat (40000) @(posedge clk_i);
    num_errors = num_errors + 1;
    wrap_up;
  end
endmodule

bind readout_ctrl readout_ctrl_sva chk_u (.clk_i(clk_i), .nrst_i(nrst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pending_i(pending_i),
  .freeze_line_o(freeze_line_o), .enable_o(enable_o), .request_o(request_o),
  .dev_reset_o(dev_reset_o), .select_o(select_o), .mask_data_o(mask_data_o),
  .mask_shift_clock_o(mask_shift_clock_o));
